// file: shared/sdram_cmd_consts.svh
// constants of the special command modes block
// assumes single data rate memory with a 4-bit command word {cs,ras,cas,we}
`ifndef SDRAM_CMD_CONSTS_SVH
`define SDRAM_CMD_CONSTS_SVH
`define CMD_DESEL 4'h8
`define CMD_NOP 4'h7
`define CMD_ACT 4'h3
`define CMD_RD 4'h5
`define CMD_WR 4'h4
`define CMD_PRE 4'h2
`define CMD_REF 4'h1
`define CMD_MRS 4'h0
`define MODE_NORMAL 3'h0
`define MODE_PRE 3'h1
`define MODE_REF 3'h2
`define MODE_MRS 3'h3
`define MODE_LOAD_DEF 3'h4
`define MODE_PROG_DEF 3'h5
`define AP_BIT 10
`define OP_PROG 8'h40
`define OP_STAT 8'h70
`define OP_W 8
`define TRC_BASE 5'h02
`define STAT_W 8
`endif

// file: shared/sdram_cmd_pkg.sv
// types of the special command modes block
// assumes the constants header is compiled alongside
package sdram_cmd_pkg;
  // gray along idle-act-rcd-rw-cl-done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACT = 3'h1,
    ST_RCD = 3'h3,
    ST_RW = 3'h2,
    ST_CL = 3'h6,
    ST_DONE = 3'h7,
    ST_WRC = 3'h4
  } state_e;
endpackage

// file: tb/sdram_mem_model.sv
// memory device stand-in: answers reads after the cas latency
// assumes registered active-low commands from the sequencer
`timescale 1ns/100ps
`include "sdram_cmd_consts.svh"
module sdram_mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] cmd,
  input wire logic [1:0] cas_latency,
  output logic [31:0] dq
);
  logic [1:0] left_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      left_r <= 2'h0;
    end else if (cmd == `CMD_RD) begin
      // the read is registered by the memory on this edge; data stands for the
      // sampling edge that lies cas_latency edges later
      left_r <= cas_latency;
    end else if (left_r != 2'h0) begin
      left_r <= left_r - 2'h1;
    end
  end
  // off the read slot the bus shows the inverse, so a stale sample cannot match
  assign dq = (left_r == 2'h1) ? 32'hC35A_96E1 : 32'h3CA5_691E;
endmodule

// file: tb/tb_sdram_special_command_modes.sv
// self-checking bench for the special command sequencer
// assumes the memory model drives read data; latency 2 or 3 only
`timescale 1ns/100ps
`include "sdram_cmd_consts.svh"
module tb_sdram_special_command_modes;
  typedef struct {
    logic [3:0] c;
    logic [1:0] b;
    logic [12:0] a;
    logic o;
    logic [31:0] d;
    int t;
  } ent_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] operating_mode_select = 3'h0;
  logic [3:0] refresh_cycle_timer_field = 4'h3;
  logic [1:0] cas_latency = 2'h2;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_row = 13'h0000;
  logic [10:0] req_col = 11'h000;
  logic [31:0] req_wdata = 32'h0;
  logic req_ack, busy, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe;
  logic [31:0] rd_data, sd_dq_i, sd_dq_o;
  logic [1:0] sd_ba;
  logic [12:0] sd_a;
  wire logic [3:0] cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int oe_cnt = 0;
  int n, t1, o1;
  ent_s q[$];
  ent_s e;
  sdram_special_cmd #(.RCD_CLKS(2)) i_sdram_special_cmd (.ref_clk, .rst,
    .operating_mode_select, .refresh_cycle_timer_field, .cas_latency, .req_valid,
    .req_write, .req_bank, .req_row, .req_col, .req_wdata, .req_ack, .rd_data, .busy,
    .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_ba, .sd_a, .sd_dq_i, .sd_dq_o, .sd_dq_oe);
  sdram_mem_model i_sdram_mem_model (.ref_clk, .rst, .cmd, .cas_latency, .dq(sd_dq_i));
  always #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cyc++;
    if (sd_dq_oe === 1'b1) oe_cnt++;
    if (!(cmd inside {`CMD_NOP, `CMD_DESEL})) begin
      q.push_back('{cmd, sd_ba, sd_a, sd_dq_oe, sd_dq_o, cyc});
    end
    if (cyc == 2000) begin
      failures++;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] v, input logic [31:0] x);
    checks++;
    if (v !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", s, x, v);
    end
  endtask
  task nxt;
    if (q.size() == 0) e.c = 4'hF;
    else e = q.pop_front();
  endtask
  // long enough for the refresh spacing timer to run out
  task gap;
    repeat (20) @(posedge ref_clk);
    #1;
    q.delete();
    o1 = oe_cnt;
  endtask
  task acc(input logic [2:0] m, input logic w, input logic [1:0] b, input logic [12:0] r,
           input logic [31:0] d);
    operating_mode_select = m;
    req_write = w;
    req_bank = b;
    req_row = r;
    req_col = 11'h055;
    req_wdata = d;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
      n++;
    end while (req_ack !== 1'b1 && n < 40);
    chk("busy_ack", busy, 1'b1);
    @(posedge ref_clk);
    #1;
    chk("busy_end", busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_pre;
    gap;
    acc(3'h1, 1'b0, 2'h2, 13'h0155, 32'h0);
    chk("pre_len", n, 1);
    nxt;
    chk("pre_cmd", e.c, `CMD_PRE);
    chk("pre_a10", e.a[10], 1'b0);
    chk("pre_ba", e.b, 2'h2);
    acc(3'h1, 1'b1, 2'h1, 13'h0400, 32'hFFFF_FFFF);
    nxt;
    chk("pall_a10", e.a[10], 1'b1);
    chk("pre_extra", q.size(), 0);
    $display("test precharge done");
  endtask
  task t_ref;
    gap;
    acc(3'h2, 1'b1, 2'h3, 13'h1FFF, 32'hDEAD_BEEF);
    chk("ref_len", n, 1);
    acc(3'h2, 1'b0, 2'h3, 13'h1FFF, 32'h0);
    nxt;
    chk("ref_cmd", e.c, `CMD_REF);
    t1 = e.t;
    nxt;
    chk("ref_cmd2", e.c, `CMD_REF);
    chk("ref_gap", (e.t - t1) >= 5, 1'b1);
    chk("ref_oe", oe_cnt - o1, 0);
    $display("test refresh done");
  endtask
  task t_open;
    gap;
    acc(3'h0, 1'b1, 2'h1, 13'h0ABC, 32'h1234_5678);
    chk("wr_len", n, 4);
    nxt;
    chk("act_row", {e.c, e.a}, {`CMD_ACT, 13'h0ABC});
    nxt;
    chk("wr_cmd", {e.c, e.o}, {`CMD_WR, 1'b1});
    chk("wr_dat", e.d, 32'h1234_5678);
    acc(3'h2, 1'b0, 2'h1, 13'h0000, 32'h0);
    chk("ref_open_len", n, 2);
    nxt;
    chk("ref_pall", {e.c, e.a[10]}, {`CMD_PRE, 1'b1});
    nxt;
    chk("ref_after", e.c, `CMD_REF);
    $display("test open row done");
  endtask
  task t_mrs;
    gap;
    acc(3'h1, 1'b0, 2'h0, 13'h0400, 32'h0); // all banks closed first
    gap;
    acc(3'h3, 1'b1, 2'h1, 13'h0032, 32'hFFFF_FFFF);
    chk("mrs_len", n, 1);
    nxt;
    chk("mrs_cmd", {e.c, e.b, e.a}, {`CMD_MRS, 2'h1, 13'h0032});
    chk("mrs_oe", oe_cnt - o1, 0);
    $display("test mode set done");
  endtask
  task t_load;
    gap;
    acc(3'h1, 1'b0, 2'h0, 13'h0400, 32'h0);
    gap;
    acc(`MODE_LOAD_DEF, 1'b1, 2'h3, 13'h0090, 32'h0);
    chk("load_len", n, 1);
    nxt;
    chk("load_cmd", {e.c, e.b, e.a}, {`CMD_REF, 2'h3, 13'h0090});
    acc(3'h0, 1'b0, 2'h3, 13'h0012, 32'h0); // same bank as the load command
    chk("rd_len", n, 6);
    nxt;
    chk("load_act", {e.c, e.b}, {`CMD_ACT, 2'h3});
    nxt;
    chk("load_rd", {e.c, e.b}, {`CMD_RD, 2'h3});
    chk("rd_data", rd_data, 32'hC35A_96E1);
    $display("test load command done");
  endtask
  task t_prog;
    gap;
    acc(3'h1, 1'b0, 2'h0, 13'h0400, 32'h0);
    gap;
    acc(`MODE_PROG_DEF, 1'b1, 2'h2, 13'h0777, 32'hCAFE_F00D);
    chk("pw_len", n, 5);
    nxt;
    chk("pw_load", {e.c, e.b, e.a[7:0]}, {`CMD_REF, 2'h2, 8'h40});
    nxt;
    chk("pw_act", {e.c, e.b, e.a}, {`CMD_ACT, 2'h2, 13'h0777});
    nxt;
    chk("pw_wr", {e.c, e.b, e.o}, {`CMD_WR, 2'h2, 1'b1});
    chk("pw_dat", e.d, 32'hCAFE_F00D);
    for (int l = 2; l <= 3; l++) begin
      cas_latency = l[1:0];
      gap;
      acc(3'h1, 1'b0, 2'h0, 13'h0400, 32'h0);
      gap;
      acc(`MODE_PROG_DEF, 1'b0, 2'h1, 13'h0321, 32'h0);
      chk("pr_len", n, 5 + l);
      nxt;
      chk("pr_load", {e.c, e.b, e.a[7:0]}, {`CMD_REF, 2'h1, 8'h70});
      nxt;
      chk("pr_act", {e.c, e.b, e.a}, {`CMD_ACT, 2'h1, 13'h0321});
      nxt;
      chk("pr_rd", {e.c, e.b}, {`CMD_RD, 2'h1});
      chk("pr_stat", rd_data, 32'h0000_00E1);
    end
    $display("test program mode done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_pre;
    t_ref;
    t_open;
    t_mrs;
    t_load;
    t_prog;
    stop_test;
  end
endmodule

// file: verilog/sdram_special_cmd.sv
// memory command sequencer for normal and special command modes
// assumes one-cycle request pulses taken only while idle, ack pulse ends each
`timescale 1ns/100ps
`include "sdram_cmd_consts.svh"
module sdram_special_cmd #(
  parameter int RCD_CLKS = 2,
  parameter logic [2:0] MODE_LOAD = `MODE_LOAD_DEF,
  parameter logic [2:0] MODE_PROG = `MODE_PROG_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] operating_mode_select,
  input wire logic [3:0] refresh_cycle_timer_field,
  input wire logic [1:0] cas_latency,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_bank,
  input wire logic [12:0] req_row,
  input wire logic [10:0] req_col,
  input wire logic [31:0] req_wdata,
  output logic req_ack,
  output logic [31:0] rd_data,
  output logic busy,
  output logic sd_cs_n,
  output logic sd_ras_n,
  output logic sd_cas_n,
  output logic sd_we_n,
  output logic [1:0] sd_ba,
  output logic [12:0] sd_a,
  input wire logic [31:0] sd_dq_i,
  output logic [31:0] sd_dq_o,
  output logic sd_dq_oe
);

  sdram_cmd_pkg::state_e state_r;
  logic [3:0] cmd_r;
  logic [1:0] ba_r;
  logic [12:0] a_r;
  logic [31:0] dq_r;
  logic oe_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic open_r;
  logic [4:0] trc_r;
  logic [3:0] cnt_r;
  logic wr_r;
  logic fl_r;
  logic [1:0] bank_r;
  logic [12:0] row_r;
  logic [10:0] col_r;
  logic [31:0] wd_r;
  logic take;
  logic [2:0] md;
  logic busy_r;

  assign take = req_valid && (state_r == sdram_cmd_pkg::ST_IDLE);
  assign md = operating_mode_select;
  assign sd_cs_n = cmd_r[3];
  assign sd_ras_n = cmd_r[2];
  assign sd_cas_n = cmd_r[1];
  assign sd_we_n = cmd_r[0];
  assign sd_ba = ba_r;
  assign sd_a = a_r;
  assign sd_dq_o = dq_r;
  assign sd_dq_oe = oe_r;
  assign req_ack = ack_r;
  assign rd_data = rdat_r;
  // kept as a flop that tracks state_r != idle, so the port has no logic behind it
  assign busy = busy_r;

  ////////////////////////////////////////////////////////////////////
  // request capture

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_r <= 1'b0;
      fl_r <= 1'b0;
      bank_r <= 2'h0;
      row_r <= 13'h0000;
      col_r <= 11'h000;
      wd_r <= 32'h00000000;
    end else if (take) begin
      wr_r <= req_write;
      fl_r <= (md == MODE_PROG);
      bank_r <= req_bank;
      row_r <= req_row;
      col_r <= req_col;
      wd_r <= req_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= sdram_cmd_pkg::ST_IDLE;
      cmd_r <= `CMD_DESEL;
      ba_r <= 2'h0;
      a_r <= 13'h0000;
      dq_r <= 32'h00000000;
      oe_r <= 1'b0;
      ack_r <= 1'b0;
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
    end else begin
      cmd_r <= `CMD_NOP;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      unique case (state_r)
        sdram_cmd_pkg::ST_IDLE: begin
          if (take) begin
            busy_r <= 1'b1;
            ba_r <= req_bank;
            a_r <= req_row;
            unique case (md)
              `MODE_PRE: begin
                cmd_r <= `CMD_PRE; // A10 taken from row bit
                ack_r <= 1'b1;
                state_r <= sdram_cmd_pkg::ST_DONE;
              end
              `MODE_REF: begin
                ba_r <= 2'h0; // lower lines ignored
                a_r <= 13'h0000;
                if (open_r) begin
                  cmd_r <= `CMD_PRE;
                  a_r[`AP_BIT] <= 1'b1;
                  state_r <= sdram_cmd_pkg::ST_WRC;
                end else if (trc_r == 5'h00) begin
                  cmd_r <= `CMD_REF; // data never driven
                  ack_r <= 1'b1;
                  state_r <= sdram_cmd_pkg::ST_DONE;
                end else begin
                  state_r <= sdram_cmd_pkg::ST_WRC;
                end
              end
              `MODE_MRS: begin
                cmd_r <= `CMD_MRS; // value on row and bank
                ack_r <= 1'b1;
                state_r <= sdram_cmd_pkg::ST_DONE;
              end
              MODE_LOAD: begin
                cmd_r <= `CMD_REF; // same encoding as refresh
                ack_r <= 1'b1;
                state_r <= sdram_cmd_pkg::ST_DONE;
              end
              MODE_PROG: begin
                cmd_r <= `CMD_REF; // load command opens triplet
                a_r[`OP_W-1:0] <= req_write ? `OP_PROG : `OP_STAT;
                state_r <= sdram_cmd_pkg::ST_ACT;
              end
              default: begin
                // normal access: rows left open, so close them first
                if (open_r) begin
                  cmd_r <= `CMD_PRE;
                  a_r[`AP_BIT] <= 1'b1;
                  state_r <= sdram_cmd_pkg::ST_ACT;
                end else begin
                  cmd_r <= `CMD_ACT;
                  cnt_r <= 4'(RCD_CLKS);
                  state_r <= sdram_cmd_pkg::ST_RCD;
                end
              end
            endcase
          end
        end
        sdram_cmd_pkg::ST_WRC: begin
          if (trc_r == 5'h00) begin
            cmd_r <= `CMD_REF;
            ba_r <= 2'h0;
            a_r <= 13'h0000;
            ack_r <= 1'b1;
            state_r <= sdram_cmd_pkg::ST_DONE;
          end
        end
        sdram_cmd_pkg::ST_ACT: begin
          cmd_r <= `CMD_ACT; // bank reused from load
          ba_r <= bank_r;
          a_r <= row_r;
          cnt_r <= 4'(RCD_CLKS);
          state_r <= sdram_cmd_pkg::ST_RCD;
        end
        sdram_cmd_pkg::ST_RCD: begin
          if (cnt_r == 4'h1) begin
            cmd_r <= wr_r ? `CMD_WR : `CMD_RD;
            ba_r <= bank_r;
            a_r <= {2'h0, col_r};
            a_r[`AP_BIT] <= 1'b0;
            dq_r <= wd_r; // data with the write command
            oe_r <= wr_r;
            state_r <= sdram_cmd_pkg::ST_RW;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        sdram_cmd_pkg::ST_RW: begin
          if (wr_r) begin
            ack_r <= 1'b1;
            state_r <= sdram_cmd_pkg::ST_DONE;
          end else begin
            cnt_r <= {2'h0, cas_latency};
            state_r <= sdram_cmd_pkg::ST_CL;
          end
        end
        sdram_cmd_pkg::ST_CL: begin
          if (cnt_r <= 4'h1) begin
            ack_r <= 1'b1;
            state_r <= sdram_cmd_pkg::ST_DONE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        sdram_cmd_pkg::ST_DONE: begin
          state_r <= sdram_cmd_pkg::ST_IDLE;
          busy_r <= 1'b0;
        end
        default: begin
          state_r <= sdram_cmd_pkg::ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data, status masked to the low byte

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdat_r <= 32'h00000000;
    end else if (state_r == sdram_cmd_pkg::ST_CL && cnt_r <= 4'h1) begin
      rdat_r <= fl_r ? {24'h000000, sd_dq_i[`STAT_W-1:0]} : sd_dq_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // open-row tracking and refresh spacing

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      open_r <= 1'b0;
    end else if (cmd_r == `CMD_ACT) begin
      open_r <= 1'b1;
    end else if (cmd_r == `CMD_PRE && a_r[`AP_BIT]) begin
      open_r <= 1'b0;
    end
  end

  // the load command, alone or opening a triplet, shares the refresh code;
  // it is timed too, a harmless extra wait
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trc_r <= 5'h00;
    end else if (cmd_r == `CMD_REF) begin
      trc_r <= {1'b0, refresh_cycle_timer_field} + `TRC_BASE;
    end else if (trc_r != 5'h00) begin
      trc_r <= trc_r - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic single_m;
  assign single_m = (md == `MODE_PRE) || (md == `MODE_MRS) || (md == MODE_LOAD);

  sequence s_load;
    cmd_r == `CMD_REF;
  endsequence
  sequence s_act;
    cmd_r == `CMD_ACT;
  endsequence

  // marks a refresh that the sequencer issues; a load command shares the code
  // but may follow a refresh at once, so it must not count here
  logic ref_cmd_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_cmd_r <= 1'b0;
    end else begin
      ref_cmd_r <= (take && md == `MODE_REF && !open_r && trc_r == 5'h00) ||
                   (state_r == sdram_cmd_pkg::ST_WRC && trc_r == 5'h00);
    end
  end

  a_pre_cmd_once: assert property (
    take && md == `MODE_PRE |=> cmd_r == `CMD_PRE ##1 cmd_r == `CMD_NOP)
    else $error("precharge not single cycle");
  a_single_two_clk: assert property (
    take && single_m |=> ack_r && state_r == sdram_cmd_pkg::ST_DONE)
    else $error("single command access not two clocks");
  a_ref_no_drive: assert property (
    cmd_r == `CMD_REF || cmd_r == `CMD_MRS |-> !oe_r)
    else $error("data bus driven during refresh or mode set");
  a_pre_before_ref: assert property (
    take && md == `MODE_REF && open_r |=> cmd_r == `CMD_PRE && sd_a[`AP_BIT])
    else $error("no precharge all before refresh");
  a_trc_spacing: assert property (
    ref_cmd_r |-> cmd_r == `CMD_REF ##1 (!ref_cmd_r) [*2])
    else $error("refresh commands too close");
  a_mrs_row_bus: assert property (
    take && md == `MODE_MRS |=> sd_a == $past(req_row) && sd_ba == $past(req_bank))
    else $error("mode value not on row lines");
  a_prog_triplet: assert property (
    take && md == MODE_PROG |=> s_load ##1 s_act ##[2:4] (cmd_r == `CMD_WR || cmd_r == `CMD_RD))
    else $error("flash triplet order broken");
  a_prog_opcode: assert property (
    take && md == MODE_PROG |=> sd_a[`OP_W-1:0] == ($past(req_write) ? `OP_PROG : `OP_STAT))
    else $error("wrong flash opcode");
  a_stat_byte: assert property (
    ack_r && fl_r && !wr_r |-> rdat_r[31:`STAT_W] == 24'h000000)
    else $error("status not on low byte");

endmodule
